//--- hw/rhpi_dev_end.sv
`timescale 1ns/1ps
module rhpi_dev_end (
   // Clock and reset.
   input wire logic sys_clk,
   input wire logic rstn,
   // Link toward the host.
   rhpi_if.dev link,
   // Event pulses from the radio core.
   input wire logic ev_tx_ready,
   input wire logic ev_fifo_level,
   input wire logic ev_overflow,
   input wire logic ev_wakeup,
   input wire logic ev_low_batt,
   // External interrupt pin, asynchronous.
   input wire logic external_interrupt_input_n,
   // Configuration levels.
   input wire logic tx_reg_enable,
   input wire logic fifo_enable,
   input wire logic digital_filter,
   input wire logic tx_reg_access,
   input wire logic rx_mode,
   // Receive side data from the radio core.
   input wire logic rx_data_bit,
   input wire logic recovered_clock,
   input wire logic raw_baseband,
   input wire logic [3:0] fifo_level,
   input wire logic [3:0] fifo_limit,
   input wire logic fifo_bit,
   // Results toward the radio core.
   output logic tx_mod_bit,
   output logic fifo_pop,
   output logic [15:0] cmd_word,
   output logic cmd_valid
);
   // Synchroniser stages: sclk, select_n, sdi, data pin, external interrupt.
   logic [4:0] in_m_q;
   logic [4:0] in_s_q;
   logic [4:0] in_p_q;
   // Decoded synchronised levels and edges.
   logic sck_rise;
   logic sck_fall;
   logic cs_fall;
   logic cs_rise;
   logic in_frame;
   logic fifo_rd;
   logic ext_fall;
   // Sticky event flags and the copy taken at frame start.
   logic [5:0] flags_q;
   logic [5:0] snap_q;
   logic [5:0] set_w;
   logic [5:0] clr_w;
   // Frame shifters and bit counter.
   logic [15:0] shin_q;
   logic [15:0] shout_q;
   logic [4:0] cnt_q;
   logic [15:0] status_w;
   // Registered pin and user outputs.
   logic sdo_q;
   logic fifo_out_q;
   logic irq_n_q;
   logic dfs_oe_q;
   logic dfs_out_q;
   logic rc_q;
   logic tx_mod_q;
   logic pop_q;
   logic [15:0] cmd_q;
   logic valid_q;

   // Every pin from the host passes two flops; the third stage only feeds edge detection.
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         in_m_q <= 5'h1E;
         in_s_q <= 5'h1E;
         in_p_q <= 5'h1E;
      end else begin
         in_m_q <= {external_interrupt_input_n, link.data_or_fifo_select, link.sdi,
                    link.select_n, link.sclk};
         in_s_q <= in_m_q;
         in_p_q <= in_s_q;
      end
   end

   assign sck_rise = in_s_q[0] & ~in_p_q[0];
   assign sck_fall = ~in_s_q[0] & in_p_q[0];
   assign cs_fall = ~in_s_q[1] & in_p_q[1];
   assign cs_rise = in_s_q[1] & ~in_p_q[1];
   assign in_frame = ~in_s_q[1];
   // A FIFO read needs the FIFO on, the select pin low and no command frame open.
   assign fifo_rd = fifo_enable & ~in_s_q[3] & in_s_q[1];
   assign ext_fall = ~in_s_q[4] & in_p_q[4];

   // Event sources in status bit order from bit 15 down.
   assign set_w = {ev_tx_ready | ev_fifo_level, 1'b0, ev_overflow, ev_wakeup,
                   ext_fall, ev_low_batt};
   // Only flags that were reported in a complete frame are cleared.
   assign clr_w = (cs_rise && cnt_q == rhpi_pkg::FULL_CNT) ? snap_q : 6'h00;
   assign status_w = {flags_q, 6'h00, fifo_level};

   // Sticky flags: the power-on flag starts set, and a new event beats a clear.
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         flags_q <= rhpi_pkg::FLAGS_RST;
      end else begin
         flags_q <= (flags_q & ~clr_w) | set_w;
      end
   end

   // The request stays low while any flag is pending, so a missed edge cannot lose it.
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         irq_n_q <= 1'b1;
      end else begin
         irq_n_q <= ~|flags_q;
      end
   end

   // Receive shifter and bit counter; counting stops above a full frame.
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         shin_q <= 16'h0000;
         cnt_q <= 5'h00;
      end else if (cs_fall) begin
         cnt_q <= 5'h00;
      end else if (in_frame && sck_rise) begin
         shin_q <= {shin_q[14:0], in_s_q[2]};
         if (cnt_q != rhpi_pkg::FULL_CNT) begin
            cnt_q <= cnt_q + 5'h01;
         end
      end
   end

   // Status shifter: loaded as select falls, stepped on each falling serial clock.
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         shout_q <= 16'h0000;
         snap_q <= 6'h00;
      end else if (cs_fall) begin
         shout_q <= status_w;
         snap_q <= flags_q;
      end else if (in_frame && sck_fall) begin
         shout_q <= {shout_q[14:0], 1'b0};
      end
   end

   // A frame counts only if select rose after sixteen or more clocks; shorter ones vanish.
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         cmd_q <= 16'h0000;
         valid_q <= 1'b0;
      end else begin
         valid_q <= 1'b0;
         if (cs_rise && cnt_q == rhpi_pkg::FULL_CNT) begin
            cmd_q <= shin_q;
            valid_q <= 1'b1;
         end
      end
   end

   // FIFO read: each rising serial clock takes the next bit and asks the core to pop.
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         fifo_out_q <= 1'b0;
         pop_q <= 1'b0;
      end else begin
         pop_q <= 1'b0;
         if (fifo_rd && sck_rise) begin
            fifo_out_q <= fifo_bit;
            pop_q <= 1'b1;
         end
      end
   end

   // Serial output: FIFO bits during a FIFO read, status shifter bits otherwise.
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         sdo_q <= 1'b0;
      end else if (fifo_rd) begin
         sdo_q <= fifo_out_q;
      end else begin
         sdo_q <= shout_q[15];
      end
   end

   // Data pin drive; the pull-high during transmit register access takes precedence.
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         dfs_oe_q <= 1'b0;
         dfs_out_q <= 1'b1;
      end else if (tx_reg_access) begin
         dfs_oe_q <= 1'b1;
         dfs_out_q <= 1'b1;
      end else if (!fifo_enable && rx_mode) begin
         dfs_oe_q <= 1'b1;
         dfs_out_q <= rx_data_bit;
      end else begin
         dfs_oe_q <= 1'b0;
         dfs_out_q <= 1'b1;
      end
   end

   // Direct modulation follows the synchronised pin; the low-current hazard in sleep is
   // the host's to avoid, since a driven-low pin is simply read as a zero here.
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         tx_mod_q <= 1'b0;
      end else begin
         tx_mod_q <= ~tx_reg_enable & in_s_q[3];
      end
   end

   // Multiplexed pin: analog filter first, then FIFO full, else recovered clock.
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         rc_q <= 1'b0;
      end else if (!digital_filter) begin
         rc_q <= raw_baseband;
      end else if (fifo_enable) begin
         rc_q <= (fifo_level >= fifo_limit);
      end else begin
         rc_q <= recovered_clock;
      end
   end

   // Outputs.
   assign link.sdo = sdo_q;
   assign link.host_interrupt_request_n = irq_n_q;
   assign link.dfs_dev_oe = dfs_oe_q;
   assign link.dfs_dev_out = dfs_out_q;
   assign link.recovered_clock_fifo_full_pin = rc_q;
   assign tx_mod_bit = tx_mod_q;
   assign fifo_pop = pop_q;
   assign cmd_word = cmd_q;
   assign cmd_valid = valid_q;
endmodule // rhpi_dev_end

//--- hw/rhpi_host_end.sv
`timescale 1ns/1ps
module rhpi_host_end (
   // Clock and reset.
   input wire logic sys_clk,
   input wire logic rstn,
   // APB slave.
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   output logic irq,
   // Link toward the device.
   rhpi_if.host link
);
   // Synchroniser for sdo, interrupt request, multiplexed pin and the shared data pin.
   logic [3:0] in_m_q;
   logic [3:0] in_s_q;
   logic rc_p_q;
   // Sequencer.
   rhpi_pkg::rhpi_hst_e st_q;
   logic [3:0] div_q;
   logic [4:0] bit_q;
   logic [15:0] txsh_q;
   logic [15:0] rxsh_q;
   logic [15:0] resp_q;
   logic sclk_q;
   logic cs_n_q;
   logic mosi_q;
   logic fifo_q;
   logic done_q;
   logic half_end;
   // Registers.
   logic [2:0] istat_q;
   logic [2:0] imask_q;
   logic [1:0] pin_q;
   logic [31:0] prdata_q;
   logic wr;
   logic start;
   logic [2:0] set_w;
   logic [2:0] w1c_w;

   assign wr = psel & penable & pwrite;
   assign start = wr && paddr == rhpi_pkg::A_CMD && st_q == rhpi_pkg::HS_IDLE;
   assign half_end = div_q == rhpi_pkg::SCLK_HALF_M1;

   // Pins from the device pass two flops before any use.
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         in_m_q <= 4'hA;
         in_s_q <= 4'hA;
         rc_p_q <= 1'b0;
      end else begin
         // The data pin is also driven by the device, so it is synchronised like the rest.
         in_m_q <= {link.data_or_fifo_select, link.recovered_clock_fifo_full_pin,
                    link.host_interrupt_request_n, link.sdo};
         in_s_q <= in_m_q;
         rc_p_q <= in_s_q[2];
      end
   end

   // Frame sequencer; a write while busy is dropped, software polls the busy bit.
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         st_q <= rhpi_pkg::HS_IDLE;
         div_q <= 4'h0;
         bit_q <= 5'h00;
         txsh_q <= 16'h0000;
         rxsh_q <= 16'h0000;
         resp_q <= 16'h0000;
         sclk_q <= 1'b0;
         cs_n_q <= 1'b1;
         mosi_q <= 1'b0;
         fifo_q <= 1'b0;
         done_q <= 1'b0;
      end else begin
         done_q <= 1'b0;
         div_q <= half_end ? 4'h0 : div_q + 4'h1;
         unique case (st_q)
            rhpi_pkg::HS_IDLE: begin
               div_q <= 4'h0;
               if (start) begin
                  txsh_q <= pwdata[15:0];
                  fifo_q <= pwdata[rhpi_pkg::CMD_FIFO];
                  // A FIFO read clocks with select left high.
                  cs_n_q <= pwdata[rhpi_pkg::CMD_FIFO];
                  mosi_q <= pwdata[15];
                  bit_q <= 5'h00;
                  st_q <= rhpi_pkg::HS_LOW;
               end
            end
            rhpi_pkg::HS_LOW: begin
               if (half_end) begin
                  sclk_q <= 1'b1;
                  st_q <= rhpi_pkg::HS_HIGH;
               end
            end
            rhpi_pkg::HS_HIGH: begin
               // Sample late in the high half so the device's delayed answer has settled.
               if (half_end) begin
                  sclk_q <= 1'b0;
                  rxsh_q <= {rxsh_q[14:0], in_s_q[0]};
                  txsh_q <= {txsh_q[14:0], 1'b0};
                  mosi_q <= txsh_q[14];
                  bit_q <= bit_q + 5'h01;
                  st_q <= (bit_q == rhpi_pkg::LAST_BIT) ? rhpi_pkg::HS_TRAIL : rhpi_pkg::HS_LOW;
               end
            end
            rhpi_pkg::HS_TRAIL: begin
               // Select is held over all sixteen clocks and released only after them.
               if (half_end) begin
                  cs_n_q <= 1'b1;
                  st_q <= rhpi_pkg::HS_GAP;
               end
            end
            rhpi_pkg::HS_GAP: begin
               // High gap before the next frame so each word stands alone.
               if (half_end) begin
                  resp_q <= rxsh_q;
                  done_q <= 1'b1;
                  st_q <= rhpi_pkg::HS_IDLE;
               end
            end
         endcase
      end
   end

   // Interrupt events: frame done, device request low, FIFO full rising.
   assign set_w = {in_s_q[2] & ~rc_p_q & ~fifo_q, ~in_s_q[1], done_q};
   assign w1c_w = (wr && paddr == rhpi_pkg::A_ISTAT) ? pwdata[2:0] : 3'h0;

   // Sticky status, write one to clear; a same-cycle event wins.
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         istat_q <= 3'h0;
      end else begin
         istat_q <= (istat_q & ~w1c_w) | set_w;
      end
   end

   // Mask and pin control registers.
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         imask_q <= rhpi_pkg::IMASK_RST;
         pin_q <= rhpi_pkg::PIN_RST;
      end else if (wr && paddr == rhpi_pkg::A_IMASK) begin
         imask_q <= pwdata[2:0];
      end else if (wr && paddr == rhpi_pkg::A_PIN) begin
         // Bit 0 drives the pin, bit 1 is its level; keep it high or released in sleep.
         pin_q <= pwdata[1:0];
      end
   end

   // Read data captured in the setup cycle; unmapped addresses read zero.
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         prdata_q <= 32'h00000000;
      end else if (psel && !penable) begin
         unique case (paddr)
            rhpi_pkg::A_RESP: prdata_q <= {16'h0000, resp_q};
            rhpi_pkg::A_STAT: prdata_q <= {28'h0000000, in_s_q[2], in_s_q[1],
                                           in_s_q[3], st_q != rhpi_pkg::HS_IDLE};
            rhpi_pkg::A_ISTAT: prdata_q <= {29'h00000000, istat_q};
            rhpi_pkg::A_IMASK: prdata_q <= {29'h00000000, imask_q};
            rhpi_pkg::A_PIN: prdata_q <= {30'h00000000, pin_q};
            default: prdata_q <= 32'h00000000;
         endcase
      end
   end

   // Outputs.
   assign prdata = prdata_q;
   assign pready = 1'b1;
   assign pslverr = 1'b0;
   assign irq = |(istat_q & imask_q);
   assign link.sclk = sclk_q;
   assign link.select_n = cs_n_q;
   assign link.sdi = mosi_q;
   assign link.dfs_host_oe = pin_q[0];
   assign link.dfs_host_out = pin_q[1];
endmodule // rhpi_host_end

//--- hw/rhpi_if.sv
`timescale 1ns/1ps
interface rhpi_if;
   // Serial command port.
   logic sclk;
   logic select_n;
   logic sdi;
   logic sdo;
   // Interrupt request toward the host, active low.
   logic host_interrupt_request_n;
   // Two-way data or FIFO select pin, one driver pair per end.
   logic dfs_host_out;
   logic dfs_host_oe;
   logic dfs_dev_out;
   logic dfs_dev_oe;
   logic data_or_fifo_select;
   // Multiplexed recovered clock, FIFO full or raw baseband pin.
   logic recovered_clock_fifo_full_pin;

   // The internal pull-up holds the pin high when nobody drives it; device drive wins.
   assign data_or_fifo_select = dfs_dev_oe ? dfs_dev_out : (dfs_host_oe ? dfs_host_out : 1'b1);

   modport dev (input sclk, input select_n, input sdi, output sdo,
                output host_interrupt_request_n, output dfs_dev_out, output dfs_dev_oe,
                input data_or_fifo_select, output recovered_clock_fifo_full_pin);
   modport host (output sclk, output select_n, output sdi, input sdo,
                 input host_interrupt_request_n, output dfs_host_out, output dfs_host_oe,
                 input data_or_fifo_select, input recovered_clock_fifo_full_pin);
endinterface

//--- hw/rhpi_pkg.sv
package rhpi_pkg;
   // System clock rate and link framing.
   localparam int unsigned SYS_CLK_HZ = 40_000_000;
   localparam int unsigned FRAME_BITS = 16;
   // Half period of the serial clock the host makes, in ns, and in cycles rounded up.
   localparam int unsigned SCLK_HALF_NS = 200;
   localparam int unsigned SCLK_HALF_CYC = (SCLK_HALF_NS * (SYS_CLK_HZ / 1_000_000) + 999) / 1000;
   localparam logic [3:0] SCLK_HALF_M1 = 4'(SCLK_HALF_CYC - 1);
   localparam logic [4:0] LAST_BIT = 5'(FRAME_BITS - 1);
   localparam logic [4:0] FULL_CNT = 5'(FRAME_BITS);
   // Device status word: event flags sit in the top bits, fill level in the low nibble.
   localparam int unsigned NUM_EVENTS = 6;
   localparam int unsigned ST_TXR = 15;
   localparam int unsigned ST_POR = 14;
   localparam int unsigned ST_OVF = 13;
   localparam int unsigned ST_WAKE = 12;
   localparam int unsigned ST_EXT = 11;
   localparam int unsigned ST_LBD = 10;
   localparam logic [5:0] FLAGS_RST = 6'h10;
   // Host register byte addresses on APB.
   localparam logic [7:0] A_CMD = 8'h00;
   localparam logic [7:0] A_RESP = 8'h04;
   localparam logic [7:0] A_STAT = 8'h08;
   localparam logic [7:0] A_ISTAT = 8'h0C;
   localparam logic [7:0] A_IMASK = 8'h10;
   localparam logic [7:0] A_PIN = 8'h14;
   // Command word field: bit 16 asks for a receive FIFO read with select left high.
   localparam int unsigned CMD_FIFO = 16;
   // Host interrupt status bits and reset values.
   localparam int unsigned IS_DONE = 0;
   localparam int unsigned IS_DEV = 1;
   localparam int unsigned IS_FULL = 2;
   localparam logic [2:0] IMASK_RST = 3'h0;
   localparam logic [1:0] PIN_RST = 2'h0;
   // Host sequencer states.
   typedef enum logic [2:0] {HS_IDLE, HS_LOW, HS_HIGH, HS_TRAIL, HS_GAP} rhpi_hst_e;
endpackage

//--- test/radio_host_pin_interface_test.sv
`timescale 1ns/1ps
// Joins both ends; APB drives the host end, radio core inputs drive the device end.
module radio_host_pin_interface_test;
   // Bit pattern the fake receive FIFO hands out, first bit in bit 15.
   localparam logic [15:0] FPAT = 16'hA5C3;
   logic sys_clk, rstn, psel, penable, pwrite, pready, pslverr, irq;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   // Event pulses: tx ready, fifo level, overflow, wake, external, low battery.
   logic [5:0] evp;
   logic tx_reg_enable, fifo_enable, digital_filter, tx_reg_access, rx_mode;
   logic rx_data_bit, recovered_clock, raw_baseband, fifo_bit, tx_mod_bit, fifo_pop, cmd_valid;
   logic [3:0] fifo_level, fifo_limit;
   // Read position of the fake FIFO; only the pop process below writes it.
   logic [3:0] fidx = 4'h0;
   logic [15:0] cmd_word, got_cmd;
   int err_total, n_checks;
   // Status bit that each event is expected to set.
   int ebit[6] = '{15, 15, 13, 12, 11, 10};

   rhpi_if link ();
   rhpi_dev_end u_rhpi_dev_end (.sys_clk(sys_clk), .rstn(rstn), .link(link),
      .ev_tx_ready(evp[0]), .ev_fifo_level(evp[1]), .ev_overflow(evp[2]),
      .ev_wakeup(evp[3]), .ev_low_batt(evp[5]), .external_interrupt_input_n(~evp[4]),
      .tx_reg_enable(tx_reg_enable), .fifo_enable(fifo_enable),
      .digital_filter(digital_filter), .tx_reg_access(tx_reg_access), .rx_mode(rx_mode),
      .rx_data_bit(rx_data_bit), .recovered_clock(recovered_clock),
      .raw_baseband(raw_baseband), .fifo_level(fifo_level), .fifo_limit(fifo_limit),
      .fifo_bit(fifo_bit), .tx_mod_bit(tx_mod_bit), .fifo_pop(fifo_pop),
      .cmd_word(cmd_word), .cmd_valid(cmd_valid));
   rhpi_host_end u_rhpi_host_end (.sys_clk(sys_clk), .rstn(rstn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq), .link(link));
   rhpi_link_sva u_rhpi_link_sva (.sys_clk(sys_clk), .rstn(rstn), .sclk(link.sclk),
      .select_n(link.select_n), .host_interrupt_request_n(link.host_interrupt_request_n),
      .data_or_fifo_select(link.data_or_fifo_select));

   // The clock toggles every 12.5 ns, half of its 25 ns period.
   initial begin
      sys_clk = 1'b0;
      forever #12.5 sys_clk = ~sys_clk;
   end

   // The fake FIFO steps to its next bit on every pop, so a lost pop shifts the word.
   assign fifo_bit = FPAT[4'hF - fidx];
   always @(posedge sys_clk) begin
      if (fifo_pop === 1'b1) begin
         fidx <= fidx + 4'h1;
      end
      if (cmd_valid === 1'b1) begin
         got_cmd <= cmd_word;
      end
   end

   // Compares and counts; a mismatch is reported at once.
   task chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
      n_checks++;
      if (seen !== exp) begin
         err_total++;
         $display("wrong value %s expected %h seen %h", what, exp, seen);
      end
   endtask

   // One APB transfer; read data is taken at the edge where pready is seen.
   task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      @(posedge sys_clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge sys_clk);
      penable <= 1'b1;
      @(posedge sys_clk);
      while (pready !== 1'b1) @(posedge sys_clk);
      rd = prdata;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   // Sends one command frame, waits while busy, then leaves the reply word in rd.
   task frame(input logic [31:0] c);
      apb(1'b1, rhpi_pkg::A_CMD, c);
      apb(1'b0, rhpi_pkg::A_STAT, 32'h0);
      for (int k = 0; k < 200 && rd[0] !== 1'b0; k++) apb(1'b0, rhpi_pkg::A_STAT, 32'h0);
      // A frame that never finishes counts as a mismatch rather than passing silently.
      chk("frame finished", rd[0], 1'b0);
      apb(1'b0, rhpi_pkg::A_RESP, 32'h0);
   endtask

   // Lets synchronisers and the one-cycle pin lag settle before a port is sampled.
   task settle();
      repeat (4) @(posedge sys_clk);
      @(negedge sys_clk);
   endtask

   // Prints the verdict and stops.
   task end_sim();
      if (err_total == 0 && n_checks > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask

   // A hang is cut short well past the few thousand cycles the tests need.
   initial begin
      repeat (20000) @(posedge sys_clk);
      err_total++;
      end_sim();
   end

   // Main sequence.
   initial begin
      {rstn, psel, penable, pwrite, paddr, pwdata, evp} = '0;
      {tx_reg_access, rx_mode, rx_data_bit, recovered_clock, raw_baseband} = '0;
      {tx_reg_enable, fifo_enable, digital_filter} = 3'b101;
      fifo_level = 4'h5;
      fifo_limit = 4'h5;
      err_total = 0;
      n_checks = 0;
      repeat (4) @(posedge sys_clk);
      rstn <= 1'b1;
      // Power-on event shows at the pin and in the host status; masked, no irq.
      settle();
      chk("irq_n after reset", link.host_interrupt_request_n, 1'b0);
      chk("irq masked", irq, 1'b0);
      apb(1'b1, rhpi_pkg::A_IMASK, 32'h2);
      @(negedge sys_clk);
      chk("irq unmasked", irq, 1'b1);
      // First frame: command reaches the core, reply carries the reset flag and level.
      frame(32'hA5F0);
      chk("reply after reset", rd[15:0], 16'h4005);
      chk("command word", got_cmd, 16'hA5F0);
      apb(1'b1, rhpi_pkg::A_ISTAT, 32'h7);
      apb(1'b0, rhpi_pkg::A_ISTAT, 32'h0);
      chk("istat cleared", rd, 32'h0);
      chk("irq cleared", irq, 1'b0);
      apb(1'b0, 8'h18, 32'h0);
      chk("unmapped read", rd, 32'h0);
      chk("slave error", pslverr, 1'b0);
      // Every event source raises the request and sets its bit in the reply; tx ready and fifo level both set bit 15.
      // Inputs only ever change just after a rising edge, so each drive waits for one.
      for (int i = 0; i < 6; i++) begin
         @(posedge sys_clk);
         evp <= 6'h01 << i;
         repeat (3) @(posedge sys_clk);
         evp <= 6'h00;
         settle();
         chk("irq_n on event", link.host_interrupt_request_n, 1'b0);
         frame(32'h0);
         chk("event source", rd[15:0], (16'h1 << ebit[i]) | 16'h5);
         settle();
         chk("irq_n after frame", link.host_interrupt_request_n, 1'b1);
      end
      // Multiplexed clock pin: raw data, recovered clock, FIFO full at and below limit.
      @(posedge sys_clk);
      digital_filter <= 1'b0;
      raw_baseband <= 1'b1;
      settle();
      chk("raw baseband", link.recovered_clock_fifo_full_pin, 1'b1);
      @(posedge sys_clk);
      {digital_filter, raw_baseband, recovered_clock} <= 3'b101;
      settle();
      chk("recovered clock", link.recovered_clock_fifo_full_pin, 1'b1);
      @(posedge sys_clk);
      fifo_enable <= 1'b1;
      fifo_limit <= 4'h6;
      settle();
      chk("fifo below limit", link.recovered_clock_fifo_full_pin, 1'b0);
      @(posedge sys_clk);
      fifo_limit <= 4'h5;
      settle();
      chk("fifo at limit", link.recovered_clock_fifo_full_pin, 1'b1);
      // Frames done, device request seen and the pin's rise have all been latched by now.
      apb(1'b0, rhpi_pkg::A_ISTAT, 32'h0);
      chk("istat events", rd, 32'h7);
      // FIFO read with the select pin held low by the host: sixteen pops, MSB first.
      apb(1'b1, rhpi_pkg::A_PIN, 32'h1);
      frame(32'h10000);
      chk("fifo word", rd[15:0], FPAT);
      chk("fifo pops", fidx, 4'h0);
      // Direct modulation from the pin while the transmit register is off.
      {fifo_enable, tx_reg_enable} <= 2'b00;
      settle();
      chk("modulation low", tx_mod_bit, 1'b0);
      apb(1'b1, rhpi_pkg::A_PIN, 32'h3);
      settle();
      chk("modulation high", tx_mod_bit, 1'b1);
      // Device pulls the pin high over a host driving low, then drives received data.
      apb(1'b1, rhpi_pkg::A_PIN, 32'h1);
      tx_reg_access <= 1'b1;
      settle();
      chk("pin on tx access", link.data_or_fifo_select, 1'b1);
      @(posedge sys_clk);
      {tx_reg_access, rx_mode, rx_data_bit} <= 3'b011;
      settle();
      chk("rx data one", link.data_or_fifo_select, 1'b1);
      apb(1'b1, rhpi_pkg::A_PIN, 32'h0);
      rx_data_bit <= 1'b0;
      settle();
      chk("rx data zero", link.data_or_fifo_select, 1'b0);
      end_sim();
   end
endmodule // radio_host_pin_interface_test

//--- test/rhpi_link_sva.sv
`timescale 1ns/1ps
// Watches the serial link between the two ends of the pin interface.
module rhpi_link_sva (
   // Clock and reset.
   input wire logic sys_clk,
   input wire logic rstn,
   // Link signals.
   input wire logic sclk,
   input wire logic select_n,
   input wire logic host_interrupt_request_n,
   input wire logic data_or_fifo_select
);
   default clocking cb @(posedge sys_clk);
   endclocking
   default disable iff (!rstn);

   // Serial clock rises seen inside the current select window.
   logic [4:0] rise_q;
   // Serial clock one cycle back, for edge finding.
   logic sclk_q;

   // Counts clocks per frame; a window that ends short or long is a broken frame.
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         rise_q <= 5'h00;
         sclk_q <= 1'b0;
      end else begin
         sclk_q <= sclk;
         if (select_n) begin
            rise_q <= 5'h00;
         end else if (sclk && !sclk_q) begin
            rise_q <= rise_q + 5'h01;
         end
      end
   end

   // One high half of the serial clock, then the fall.
   sequence s_high_half;
      sclk [*8] ##1 !sclk;
   endsequence
   // One low half of the serial clock.
   sequence s_low_half;
      !sclk [*8];
   endsequence

   a_frame_bit_count: assert property ($rose(select_n) |-> rise_q == 5'h10)
      else $error("frame did not carry sixteen clocks");
   a_clock_in_frame: assert property ($rose(sclk) |-> !select_n || !data_or_fifo_select)
      else $error("serial clock outside a frame");
   a_high_half_len: assert property ($rose(sclk) |-> s_high_half)
      else $error("serial clock high half wrong length");
   a_low_half_len: assert property ($fell(sclk) && !select_n |-> s_low_half)
      else $error("serial clock low half too short");
   a_select_setup: assert property ($fell(select_n) |-> !sclk [*7])
      else $error("clock too soon after select");
   a_select_gap: assert property ($rose(select_n) |-> select_n [*8])
      else $error("select released too briefly between frames");
   a_por_irq: assert property ($rose(rstn) |-> ##[1:3] !host_interrupt_request_n)
      else $error("no interrupt request after reset");
   a_irq_cleared: assert property ($rose(select_n) |-> ##[1:12] host_interrupt_request_n)
      else $error("interrupt request not withdrawn after frame");
endmodule // rhpi_link_sva
